// File: bench/rate_codec_assertions.sv
// checker watching the level-3 parameter octet link between the two ends
`timescale 1ns/100ps
`default_nettype none
module rate_codec_assertions (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic valid_i,
  input wire logic [7:0] level3_parameter_octet_i,
  input wire logic modulation_i,
  input wire logic [1:0] range_idx_i,
  input wire logic [1:0] octet_idx_i,
  input wire logic last_i
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // top octet and step octet strobes
  wire top_w = valid_i && octet_idx_i == rate_codec_pkg::IDX_TOP;
  wire step_w = valid_i && octet_idx_i == rate_codec_pkg::IDX_STEP;
  wire [7:0] oct_w = level3_parameter_octet_i;
  property p_rsv; top_w |-> oct_w[7:3] == 5'h00; endproperty
  property p_low; valid_i && !top_w |-> oct_w[7:6] == 2'h0; endproperty
  property p_ord;
    valid_i && !step_w |=> valid_i && octet_idx_i == $past(octet_idx_i) + 2'h1;
  endproperty
  property p_grp;
    valid_i && !step_w |=> $stable(range_idx_i) && $stable(modulation_i);
  endproperty
  property p_next;
    step_w && !last_i |=> top_w && range_idx_i == $past(range_idx_i) + 2'h1 &&
      $stable(modulation_i);
  endproperty
  property p_mod;
    step_w && last_i && !modulation_i |=> top_w && modulation_i && range_idx_i == 2'h0;
  endproperty
  property p_first;
    $rose(valid_i) |-> top_w && !modulation_i && range_idx_i == 2'h0;
  endproperty
  property p_end; step_w && last_i && modulation_i |=> !valid_i; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved top bits set");
  a_low: assert property (p_low) else $error("rate octet high bits set");
  a_ord: assert property (p_ord) else $error("octet order broken");
  a_grp: assert property (p_grp) else $error("group changed mid way");
  a_next: assert property (p_next) else $error("next range misplaced");
  a_mod: assert property (p_mod) else $error("32-level field misplaced");
  a_first: assert property (p_first) else $error("field did not open on base");
  a_end: assert property (p_end) else $error("octet after field end");
  // main scenarios reached
  c_full: cover property (step_w && range_idx_i == 2'h3);
  c_end: cover property (step_w && last_i && modulation_i);
  c_top: cover property (top_w && oct_w[2:0] == 3'h7);
endmodule
`default_nettype wire

// File: bench/training_rate_field_codec_bench.sv
// bench joining encoder and decoder, plus a bench-driven second link
`timescale 1ns/100ps
`default_nettype none
module training_rate_field_codec_bench;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start_i = 1'b0;
  logic [3:0] en16 = 4'h1, en32 = 4'h1;
  rate_codec_pkg::rate_range_t [3:0] r16 = '0, r32 = '0;
  logic busy_o, done_o, bad_range_o, rv, rm, fe, rv2, rm2, fe2, exp_bad;
  logic [1:0] ri, ri2;
  rate_codec_pkg::rate_range_t ro, ro2;
  int n_fail = 0, n_checks = 0, seed = 32'hc3bd;
  logic [31:0] exq[$]; // notes {end, mod, idx, range}
  rate_link_if link();
  rate_link_if link2(); // driven by the bench
  always #50 core_clk_i = ~core_clk_i;
  rate_field_encoder rate_field_encoder_i (.core_clk_i, .reset_n_i, .start_i,
    .range_en16_i(en16), .range_en32_i(en32), .ranges16_i(r16), .ranges32_i(r32),
    .busy_o, .done_o, .bad_range_o, .link(link.device));
  rate_field_decoder rate_field_decoder_i (.core_clk_i, .reset_n_i, .link(link.remote),
    .range_valid_o(rv), .range_mod_o(rm), .range_idx_o(ri), .range_o(ro), .field_end_o(fe));
  rate_field_decoder rate_field_decoder_i2 (.core_clk_i, .reset_n_i, .link(link2.remote),
    .range_valid_o(rv2), .range_mod_o(rm2), .range_idx_o(ri2), .range_o(ro2),
    .field_end_o(fe2));
  rate_codec_assertions rate_codec_assertions_i (.core_clk_i, .reset_n_i,
    .valid_i(link.valid), .level3_parameter_octet_i(link.level3_parameter_octet),
    .modulation_i(link.modulation), .range_idx_i(link.range_idx),
    .octet_idx_i(link.octet_idx), .last_i(link.last));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge core_clk_i);
    #10;
  endtask
  // ranges sent per field: base, then up to the first disabled index
  function automatic int count(input logic [3:0] e);
    count = 1;
    while (count < 4 && e[count]) count++;
  endfunction
  // decoded ranges and wire octets against the oldest note
  always @(posedge core_clk_i) begin
    #1;
    if (rv === 1'b1) begin
      if (exq.size() == 0) cmp(32'h1, 32'h0);
      else cmp({7'h0, fe, rm, ri, ro}, exq.pop_front());
    end
    if (link.valid === 1'b1 && exq.size() != 0) begin
      if (link.octet_idx === 2'h0)
        cmp(link.level3_parameter_octet, {exq[0][6], exq[0][13], exq[0][20]});
      if (link.octet_idx === 2'h3)
        cmp(link.level3_parameter_octet, exq[0][5:0]);
    end
  end
  task automatic run_field(input logic [3:0] e16, input logic [3:0] e32);
    int n, k, w;
    rate_codec_pkg::rate_range_t rr;
    en16 = e16;
    en32 = e32;
    exp_bad = 1'b0;
    for (k = 0; k < 4; k++) begin
      r16[k] = 21'($random(seed));
      r32[k] = 21'($random(seed));
    end
    for (int m = 0; m < 2; m++) begin
      n = count(m ? e32 : e16);
      for (k = 0; k < n; k++) begin
        rr = m ? r32[k] : r16[k];
        exq.push_back({7'h0, k == n - 1, m[0], k[1:0], rr});
        if (rr.min_rate > rr.max_rate) exp_bad = 1'b1;
      end
    end
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    tick();
    cmp(busy_o, 32'h1);
    start_i = 1'b1; // ignored while busy
    tick();
    start_i = 1'b0;
    w = 0;
    while (done_o !== 1'b1 && w < 100) begin
      tick();
      w++;
    end
    cmp(done_o, 32'h1);
    cmp(bad_range_o, exp_bad);
    repeat (3) tick();
    cmp(exq.size(), 32'h0);
    $display("field test done, enables %h %h", e16, e32);
  endtask
  // one group with reserved bits set on the second link
  task automatic junk_group(input rate_codec_pkg::rate_range_t rr);
    logic [7:0] oct [4];
    oct[0] = {5'h1f, rr.step_rate[6], rr.max_rate[6], rr.min_rate[6]};
    oct[1] = {2'h3, rr.min_rate[5:0]};
    oct[2] = {2'h3, rr.max_rate[5:0]};
    oct[3] = {2'h3, rr.step_rate[5:0]};
    for (int i = 0; i < 4; i++) begin
      link2.valid = 1'b1;
      link2.octet_idx = i[1:0];
      link2.level3_parameter_octet = oct[i];
      link2.last = i == 3;
      tick();
    end
    link2.valid = 1'b0;
    link2.level3_parameter_octet = ~oct[3];
    cmp(ro2, rr);
    cmp({rv2, fe2, rm2, ri2}, 32'h1e);
    $display("reserved bit test done");
  endtask
  initial begin
    link2.valid = 1'b0;
    link2.modulation = 1'b1;
    link2.range_idx = 2'h2;
    link2.octet_idx = 2'h0;
    link2.last = 1'b0;
    link2.level3_parameter_octet = 8'h0;
    repeat (2) @(posedge core_clk_i);
    #10 reset_n_i = 1'b1;
    run_field(4'h1, 4'h1);
    run_field(4'hf, 4'hf);
    run_field(4'hb, 4'h7);
    repeat (4) run_field(4'($random(seed)) | 4'h1, 4'($random(seed)) | 4'h1);
    junk_group(21'($random(seed)));
    tally_and_finish();
  end
  // watchdog far beyond the expected few hundred cycles
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: common/rate_codec_pkg.sv
// package with octet layout constants for the training rate field codec
// Functional notes
// RQ1 - group first octet bits 1-3 carry top bits
// RQ2 - first octet bits 4-6 reserved, never interpreted
// RQ3 - octets 2-4 carry low six bits
// RQ4 - rate value is seven bits, top plus six
// RQ5 - extended range j uses octets j*4-3..j*4
// RQ6 - separate 16-level and 32-level rate groups
// RQ7 - encoder sends ascending order, min not above max; a range with min above max is still sent unchanged and only flagged
`default_nettype none
package rate_codec_pkg;
  // octets in one rate group
  localparam int unsigned GROUP_OCTETS = 4;
  // rate ranges kept per modulation (base plus extended)
  localparam int unsigned RANGES = 4;
  // width of a rate value
  localparam int unsigned RATE_W = 7;
  // width of an octet
  localparam int unsigned OCTET_W = 8;
  // bit positions (bit 1 of the octet is index 0)
  localparam int unsigned MIN_TOP_POS = 0;
  localparam int unsigned MAX_TOP_POS = 1;
  localparam int unsigned STEP_TOP_POS = 2;
  localparam int unsigned LOW_W = 6;
  // modulation selectors
  localparam logic MOD_16 = 1'b0;
  localparam logic MOD_32 = 1'b1;
  // octet index within a group
  localparam logic [1:0] IDX_TOP = 2'h0;
  localparam logic [1:0] IDX_MIN = 2'h1;
  localparam logic [1:0] IDX_MAX = 2'h2;
  localparam logic [1:0] IDX_STEP = 2'h3;
  // total octets in one modulation field
  localparam int unsigned FIELD_OCTETS = GROUP_OCTETS * RANGES;

  // one range of rates
  typedef struct packed {
    logic [RATE_W-1:0] min_rate;
    logic [RATE_W-1:0] max_rate;
    logic [RATE_W-1:0] step_rate;
  } rate_range_t;
endpackage
`default_nettype wire

// File: common/rate_link_if.sv
// interface carrying the level-3 parameter octet stream between the two ends
`timescale 1ns/100ps
`default_nettype none
interface rate_link_if;
  // octet strobe, octet value, modulation, range index, octet index, last flag
  logic valid;
  logic [7:0] level3_parameter_octet;
  logic modulation;
  logic [1:0] range_idx;
  logic [1:0] octet_idx;
  logic last;
  // device end drives the stream
  modport device (output valid, level3_parameter_octet, modulation, range_idx,
    octet_idx, last);
  // remote end listens
  modport remote (input valid, level3_parameter_octet, modulation, range_idx,
    octet_idx, last);
endinterface
`default_nettype wire

// File: rtl/rate_field_decoder.sv
// remote end: parses the training rate octets back into rate ranges
`timescale 1ns/100ps
`default_nettype none
module rate_field_decoder (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  rate_link_if.remote link,
  output logic range_valid_o,
  output logic range_mod_o,
  output logic [1:0] range_idx_o,
  output rate_codec_pkg::rate_range_t range_o,
  output logic field_end_o
);
  // RQ4 join top bit with six low bits
  function automatic logic [6:0] join_rate(input logic top, input logic [7:0] o);
    return {top, o[5:0]};
  endfunction

  logic [2:0] top_reg; // held top bits of the current group
  logic [7:0] min_oct_reg, max_oct_reg; // held low octets
  logic is_top, is_min, is_max, is_step; // slot decode
  rate_codec_pkg::rate_range_t range_reg;
  logic valid_reg, mod_reg, end_reg;
  logic [1:0] idx_reg;

  assign is_top = link.valid && link.octet_idx == rate_codec_pkg::IDX_TOP;
  assign is_min = link.valid && link.octet_idx == rate_codec_pkg::IDX_MIN;
  assign is_max = link.valid && link.octet_idx == rate_codec_pkg::IDX_MAX;
  assign is_step = link.valid && link.octet_idx == rate_codec_pkg::IDX_STEP;

  // RQ1 RQ2 keep only bits 1-3, reserved bits ignored
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      top_reg <= 3'h0;
      min_oct_reg <= 8'h00;
      max_oct_reg <= 8'h00;
    end else begin
      if (is_top) begin
        top_reg <= link.level3_parameter_octet[2:0];
      end
      // RQ3 capture low-bit octets
      if (is_min) begin
        min_oct_reg <= link.level3_parameter_octet;
      end
      if (is_max) begin
        max_oct_reg <= link.level3_parameter_octet;
      end
    end
  end

  // RQ5 RQ6 whole range out on its step octet, tagged by modulation and index
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      valid_reg <= 1'b0;
      mod_reg <= 1'b0;
      idx_reg <= 2'h0;
      end_reg <= 1'b0;
      range_reg <= '0;
    end else begin
      valid_reg <= is_step;
      end_reg <= is_step && link.last;
      if (is_step) begin
        mod_reg <= link.modulation;
        idx_reg <= link.range_idx;
        range_reg.min_rate <= join_rate(top_reg[rate_codec_pkg::MIN_TOP_POS], min_oct_reg);
        range_reg.max_rate <= join_rate(top_reg[rate_codec_pkg::MAX_TOP_POS], max_oct_reg);
        range_reg.step_rate <= join_rate(top_reg[rate_codec_pkg::STEP_TOP_POS],
          link.level3_parameter_octet);
      end
    end
  end

  assign range_valid_o = valid_reg;
  assign range_mod_o = mod_reg;
  assign range_idx_o = idx_reg;
  assign range_o = range_reg;
  assign field_end_o = end_reg;
endmodule
`default_nettype wire

// File: rtl/rate_field_encoder.sv
// device end: builds the training rate octets for both modulations
`timescale 1ns/100ps
`default_nettype none
module rate_field_encoder (
  // clock and asynchronous active-low reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // start request, taken only while idle
  input wire logic start_i,
  // range enables, bit k for range k; bit 0 is unused, the base range is always sent
  input wire logic [3:0] range_en16_i,
  input wire logic [3:0] range_en32_i,
  // ranges to advertise per modulation, index 0 is the base range
  input wire rate_codec_pkg::rate_range_t [3:0] ranges16_i,
  input wire rate_codec_pkg::rate_range_t [3:0] ranges32_i,
  // status
  output logic busy_o,
  output logic done_o,
  output logic bad_range_o,
  // octet stream to the far end
  rate_link_if.device link
);
  // sequencer states: idle waits for a start, send walks the octets,
  // finish spends one cycle so that the done pulse follows the last octet
  typedef enum logic [1:0] {IDLE, SEND, FINISH} enc_state_t;

  // RQ1 RQ2 top-bit octet
  // first octet of a group: the top bit of each value in bits 1 to 3;
  // the upper bits stay zero, bits 4 to 6 are reserved and carry nothing
  function automatic logic [7:0] top_octet(input rate_codec_pkg::rate_range_t r);
    logic [7:0] o; // octet under construction
    o = 8'h00;
    o[rate_codec_pkg::MIN_TOP_POS] = r.min_rate[rate_codec_pkg::RATE_W-1];
    o[rate_codec_pkg::MAX_TOP_POS] = r.max_rate[rate_codec_pkg::RATE_W-1];
    o[rate_codec_pkg::STEP_TOP_POS] = r.step_rate[rate_codec_pkg::RATE_W-1];
    return o;
  endfunction

  // RQ3 RQ4 low-bit octet
  // six low bits of one value; its top bit travels in the first octet
  // of the group, and bits 7 and 8 stay zero
  function automatic logic [7:0] low_octet(input logic [6:0] v);
    return {2'h0, v[5:0]};
  endfunction

  // sequencer state and its next value
  enc_state_t state_reg, state_next;
  // field position: modulation, range and octet slot being built
  logic mod_reg; // modulation being sent
  logic [1:0] rng_reg; // range index being sent
  logic [1:0] oct_reg; // octet index in group
  // decoded view of the current slot
  rate_codec_pkg::rate_range_t cur_range; // selected range
  logic [3:0] cur_en; // enables of current modulation
  logic [7:0] octet_sel; // octet for the current slot
  logic range_ok; // min not above max
  logic group_end; // last octet of a group
  logic mod_end; // last enabled range of this modulation

  // link outputs, registered so the far end sees clean octets
  logic [7:0] octet_reg; // octet on the link
  logic valid_reg; // octet strobe
  logic last_reg; // step octet of the last range of a modulation
  logic mod_q; // modulation tag of the octet on the link
  logic [1:0] rng_q; // range tag of the octet on the link
  logic [1:0] oct_q; // slot tag of the octet on the link

  // status outputs
  logic done_reg; // one-cycle end of field
  logic bad_reg; // sticky min above max seen

  // pick the active range and its enables from the modulation being sent
  assign cur_range = (mod_reg == rate_codec_pkg::MOD_32) ? ranges32_i[rng_reg] :
    ranges16_i[rng_reg];
  assign cur_en = (mod_reg == rate_codec_pkg::MOD_32) ? range_en32_i : range_en16_i;
  // RQ7 min check
  // a range with min above max is still sent unchanged, only flagged
  assign range_ok = cur_range.min_rate <= cur_range.max_rate;
  // RQ1 RQ3 slot select
  // top octet first, then the low bits of minimum, maximum and step
  assign octet_sel = (oct_reg == rate_codec_pkg::IDX_TOP) ? top_octet(cur_range) :
    (oct_reg == rate_codec_pkg::IDX_MIN) ? low_octet(cur_range.min_rate) :
    (oct_reg == rate_codec_pkg::IDX_MAX) ? low_octet(cur_range.max_rate) :
    low_octet(cur_range.step_rate);
  // the step octet closes a group
  assign group_end = oct_reg == rate_codec_pkg::IDX_STEP;
  // RQ5 extended ranges follow while enabled
  // one modulation ends at the last index or at the first clear enable;
  // enables above a clear one are never looked at
  assign mod_end = (rng_reg == 2'(rate_codec_pkg::RANGES - 1)) || !cur_en[rng_reg + 2'h1];

  // next state: a start is taken only in idle, and one that comes
  // while busy is dropped without any sign
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE: begin
        // start accepted only when idle
        // start may be a pulse or a level
        if (start_i) begin
          state_next = SEND;
        end
      end
      SEND: begin
        // finish after the last group of the 32-level field
        // the 16-level field always comes first
        if (group_end && mod_end && mod_reg == rate_codec_pkg::MOD_32) begin
          state_next = FINISH;
        end
      end
      // one cycle for the done pulse, then back to idle
      FINISH: state_next = IDLE;
      // unused code falls back to idle
      default: state_next = IDLE;
    endcase
  end

  // state register
  // reset returns the sequencer to idle at once, in mid-field too
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // RQ6 RQ7 octet walk
  // ascending octets and ranges, the 16-level field before the 32-level one
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // field starts on the 16-level base range
      mod_reg <= rate_codec_pkg::MOD_16;
      rng_reg <= 2'h0;
      oct_reg <= 2'h0;
    end else if (state_reg != SEND) begin
      // outside send the walk waits at the start of the field
      mod_reg <= rate_codec_pkg::MOD_16;
      rng_reg <= 2'h0;
      oct_reg <= 2'h0;
    end else if (!group_end) begin
      // next octet of the same group
      oct_reg <= oct_reg + 2'h1;
    end else if (mod_end) begin
      // move to the other modulation
      mod_reg <= rate_codec_pkg::MOD_32;
      rng_reg <= 2'h0;
      oct_reg <= 2'h0;
    end else begin
      // next extended range of the same modulation
      rng_reg <= rng_reg + 2'h1;
      oct_reg <= 2'h0;
    end
  end

  // registered link outputs
  // the tags travel with the octet so that the far end can place it
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // link quiet during reset
      valid_reg <= 1'b0;
      octet_reg <= 8'h00;
      last_reg <= 1'b0;
      mod_q <= 1'b0;
      rng_q <= 2'h0;
      oct_q <= 2'h0;
    end else begin
      // one octet per cycle while sending
      valid_reg <= state_reg == SEND;
      octet_reg <= octet_sel;
      last_reg <= state_reg == SEND && group_end && mod_end;
      mod_q <= mod_reg;
      rng_q <= rng_reg;
      oct_q <= oct_reg;
    end
  end

  // done pulse and sticky range fault for the run
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_reg <= 1'b0;
      bad_reg <= 1'b0;
    end else begin
      // done follows the finish state
      done_reg <= state_reg == FINISH;
      if (state_reg == IDLE && start_i) begin
        // a taken start clears the flag of the last field
        bad_reg <= 1'b0;
      end else if (state_reg == SEND && !range_ok) begin
        // RQ7 flag min above max
        bad_reg <= 1'b1;
      end
    end
  end

  // link drive, straight from the registers
  assign link.valid = valid_reg;
  assign link.level3_parameter_octet = octet_reg;
  assign link.modulation = mod_q;
  assign link.range_idx = rng_q;
  assign link.octet_idx = oct_q;
  assign link.last = last_reg;

  // status outputs; busy rises the cycle after a start is taken
  assign busy_o = state_reg != IDLE;
  assign done_o = done_reg;
  assign bad_range_o = bad_reg;
endmodule
`default_nettype wire
